// ### design/uvm_pkg_regs.sv
// Package holding offsets, reset values and timing constants for the mode registers.
package uvm_regs_pkg;

  // ==========================================================================
  // Configuration offsets
  // ==========================================================================
  localparam logic [7:0] UVM_OFF_BAR0 = 8'h10;
  localparam logic [7:0] UVM_OFF_BAR1 = 8'h11;
  localparam logic [7:0] UVM_OFF_BAR2 = 8'h12;
  localparam logic [7:0] UVM_OFF_BAR3 = 8'h13;
  localparam logic [7:0] UVM_OFF_MINGRANT = 8'h3e;
  localparam logic [7:0] UVM_OFF_MAX_LATENCY_HINT = 8'h3f;
  localparam logic [7:0] UVM_OFF_MODE1 = 8'h44;
  localparam logic [7:0] UVM_OFF_MODE2 = 8'h45;
  localparam logic [7:0] UVM_OFF_MODE3 = 8'h46;
  localparam logic [7:0] UVM_OFF_PMDBG_LO = 8'h48;
  localparam logic [7:0] UVM_OFF_PMDBG_HI = 8'h49;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] UVM_RST_MAX_LATENCY_HINT = 8'h50;
  localparam logic [7:0] UVM_RST_MINGRANT = 8'h00;
  localparam logic [7:0] UVM_RST_MODE1 = 8'h2a;
  localparam logic [7:0] UVM_RST_MODE2 = 8'h00;
  localparam logic [7:0] UVM_RST_MODE3 = 8'h00;
  localparam logic [15:0] UVM_RST_PMDBG = 16'h0000;
  localparam logic [19:0] UVM_RST_BAR = 20'h00000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int UVM_M1_UNDERRUN = 6;
  localparam int UVM_M1_TRIPLE_N = 5;
  localparam int UVM_M1_WAKEUP = 4;
  localparam int UVM_M1_ALT_DMA = 3;
  localparam int UVM_M1_HALT = 2;
  localparam int UVM_M1_SLEEP_WS = 1;
  localparam int UVM_M1_SMALL_BUF = 0;
  localparam int UVM_M2_DLY_CLK = 7;
  localparam int UVM_M2_PORT_PWR = 5;
  localparam int UVM_M2_PM_MASK = 4;
  localparam int UVM_M2_RESUME = 3;
  localparam int UVM_M2_RESTORE = 2;
  localparam int UVM_M3_RESTORE_RDY = 0;

  // ==========================================================================
  // Timing and counts
  // ==========================================================================
  localparam int UVM_CLK_MHZ = 100;
  localparam int UVM_FS_MHZ = 12;
  localparam int UVM_FS_DIV = UVM_CLK_MHZ / UVM_FS_MHZ;
  localparam logic [3:0] UVM_FS_DIV_LAST = 4'(UVM_FS_DIV - 1);
  localparam logic [2:0] UVM_SUSP_CLKS = 3'h4;
  localparam logic [1:0] UVM_ERR_LIMIT = 2'h3;
  localparam logic [4:0] UVM_BUF_SMALL = 5'h10;
  localparam logic [5:0] UVM_BUF_LARGE = 6'h20;

endpackage

// ### design/uvm_mode_regs.sv
// Mode register bank of the host controller with its control effects.
// Notes on behaviour
// - Max latency reads 50h at 3Fh.
// - First mode register resets to 2ah.
// - Bit 6 resets buffer pointer on underrun.
// - Bit 5 low: error after three events.
// - Bit 4 gates both wakeup control bits.
// - Bit 3 selects alternate DMA path.
// - Bit 2 halts buffer until next access.
// - Bit 1 allows waitstate write while no device is attached.
// - Bit 0: 16 byte region, else 32.
// - Second mode register resets to 00h.
// - Bit 7: four 12 MHz clocks before suspend.
// - Port power bit zero blocks bus drivers.
// - Bit 4 masks power management status.
// - Bit 3 drives resume in deep sleep.
// - Bit 2 restores registers after S3/S4.
// - Third register bit 0 restores after S3.
// - 16-bit reserved register at 48h, reset zero.
// - Operational block decoded at programmed base.
// - Wakeup enable plus resume signals wakeup.
`timescale 1ns/100ps
`default_nettype none

module uvm_mode_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration byte port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Memory decode for the operational block
  input wire logic [31:0] mem_addr,
  input wire logic mem_valid,
  output logic op_hit,
  // Controller events
  input wire logic data_underrun,
  input wire logic err_event,
  input wire logic buf_access,
  input wire logic no_device,
  input wire logic suspend_req,
  input wire logic resume_detect,
  input wire logic sleep_exit_s3,
  input wire logic sleep_exit_s4,
  input wire logic deep_sleep,
  input wire logic wake_connected_wr,
  input wire logic wake_enable_wr,
  input wire logic wake_wr,
  // Controls to the controller
  output logic buf_ptr_reset,
  output logic err_irq,
  output logic wakeup_connected_flag,
  output logic wakeup_enable_flag,
  output logic alternate_bus_data_path,
  output logic buffer_halted,
  output logic sleep_ws_write_ok,
  output logic [5:0] buf_region_bytes,
  output logic fs_clk_out,
  output logic suspend_enter,
  output logic port_drive_en,
  output logic pm_status_masked,
  output logic resume_drive,
  output logic restore_start,
  output logic wakeup_signal
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {UVM_S_IDLE, UVM_S_CLOCKS, UVM_S_SUSP} uvm_susp_t;

  typedef struct packed {
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] mode3;
    logic [15:0] pmdbg;
    logic [19:0] bar;
    logic [7:0] rdata;
    logic [1:0] err_cnt;
    logic halted;
    logic [3:0] div;
    logic [2:0] clk_cnt;
    uvm_susp_t susp;
    logic ptr_rst;
    logic irq;
    logic wk_conn;
    logic wk_en;
    logic fs_clk;
    logic susp_out;
    logic restore;
    logic wake;
    logic hit;
    logic [5:0] region;
    logic ws_ok;
    logic resume_drv;
  } uvm_state_t;

  uvm_state_t s_q;
  uvm_state_t s_d;

  function automatic logic [7:0] uvm_bar_byte(input logic [19:0] b,
                                              input logic [1:0] idx);
    logic [31:0] w;
    w = {b, 12'h000};
    uvm_bar_byte = w[8*idx +: 8];
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    s_d = s_q;
    s_d.ptr_rst = 1'b0;
    s_d.irq = 1'b0;
    s_d.restore = 1'b0;
    s_d.wake = 1'b0;
    // Register writes; reserved bits simply store.
    if (cfg_wr)
    begin
      case (cfg_addr)
        uvm_regs_pkg::UVM_OFF_MODE1: s_d.mode1 = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_MODE2: s_d.mode2 = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_MODE3: s_d.mode3 = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_PMDBG_LO: s_d.pmdbg[7:0] = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_PMDBG_HI: s_d.pmdbg[15:8] = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_BAR1: s_d.bar[3:0] = cfg_wdata[7:4];
        uvm_regs_pkg::UVM_OFF_BAR2: s_d.bar[11:4] = cfg_wdata;
        uvm_regs_pkg::UVM_OFF_BAR3: s_d.bar[19:12] = cfg_wdata;
        default: ;
      endcase
    end
    // Read data; unmapped offsets read zero.
    case (cfg_addr)
      uvm_regs_pkg::UVM_OFF_MAX_LATENCY_HINT:
        s_d.rdata = uvm_regs_pkg::UVM_RST_MAX_LATENCY_HINT;
      uvm_regs_pkg::UVM_OFF_MINGRANT:
        s_d.rdata = uvm_regs_pkg::UVM_RST_MINGRANT;
      uvm_regs_pkg::UVM_OFF_MODE1: s_d.rdata = s_q.mode1;
      uvm_regs_pkg::UVM_OFF_MODE2: s_d.rdata = s_q.mode2;
      uvm_regs_pkg::UVM_OFF_MODE3: s_d.rdata = s_q.mode3;
      uvm_regs_pkg::UVM_OFF_PMDBG_LO: s_d.rdata = s_q.pmdbg[7:0];
      uvm_regs_pkg::UVM_OFF_PMDBG_HI: s_d.rdata = s_q.pmdbg[15:8];
      uvm_regs_pkg::UVM_OFF_BAR0: s_d.rdata = uvm_bar_byte(s_q.bar, 2'h0);
      uvm_regs_pkg::UVM_OFF_BAR1: s_d.rdata = uvm_bar_byte(s_q.bar, 2'h1);
      uvm_regs_pkg::UVM_OFF_BAR2: s_d.rdata = uvm_bar_byte(s_q.bar, 2'h2);
      uvm_regs_pkg::UVM_OFF_BAR3: s_d.rdata = uvm_bar_byte(s_q.bar, 2'h3);
      default: s_d.rdata = 8'h00;
    endcase
    if (!cfg_rd)
      s_d.rdata = s_q.rdata;
    // Memory decode of the 4K operational window.
    s_d.hit = mem_valid && (mem_addr[31:12] == s_q.bar);
    // Underrun resets the buffer pointer when enabled.
    s_d.ptr_rst = data_underrun
      && s_q.mode1[uvm_regs_pkg::UVM_M1_UNDERRUN];
    // Error reporting, immediate or after three in a row.
    if (err_event)
    begin
      if (s_q.mode1[uvm_regs_pkg::UVM_M1_TRIPLE_N])
        s_d.irq = 1'b1;
      else if (s_q.err_cnt == uvm_regs_pkg::UVM_ERR_LIMIT - 2'h1)
      begin
        s_d.irq = 1'b1;
        s_d.err_cnt = 2'h0;
      end
      else
        s_d.err_cnt = s_q.err_cnt + 2'h1;
    end
    // Wakeup control bits only live while enabled.
    if (wake_wr)
    begin
      s_d.wk_conn = wake_connected_wr;
      s_d.wk_en = wake_enable_wr;
    end
    if (!s_q.mode1[uvm_regs_pkg::UVM_M1_WAKEUP])
    begin
      s_d.wk_conn = 1'b0;
      s_d.wk_en = 1'b0;
    end
    s_d.wake = s_q.wk_en && resume_detect;
    // Writing the halt bit stops the buffer until its next access.
    if (buf_access)
      s_d.halted = 1'b0;
    if (cfg_wr && cfg_addr == uvm_regs_pkg::UVM_OFF_MODE1
        && cfg_wdata[uvm_regs_pkg::UVM_M1_HALT])
      s_d.halted = 1'b1;
    // Restore after sleep exit.
    s_d.restore = (sleep_exit_s3
      && (s_q.mode3[uvm_regs_pkg::UVM_M3_RESTORE_RDY]
          || s_q.mode2[uvm_regs_pkg::UVM_M2_RESTORE]))
      || (sleep_exit_s4
          && s_q.mode2[uvm_regs_pkg::UVM_M2_RESTORE]);
    // Registered controls, some qualified by the controller's state.
    s_d.region = s_d.mode1[uvm_regs_pkg::UVM_M1_SMALL_BUF]
      ? {1'b0, uvm_regs_pkg::UVM_BUF_SMALL}
      : uvm_regs_pkg::UVM_BUF_LARGE;
    s_d.ws_ok = s_d.mode1[uvm_regs_pkg::UVM_M1_SLEEP_WS] && no_device;
    s_d.resume_drv = s_d.mode2[uvm_regs_pkg::UVM_M2_RESUME]
      && deep_sleep;
    // Full speed clock divider and suspend entry.
    s_d.div = (s_q.div == uvm_regs_pkg::UVM_FS_DIV_LAST) ? 4'h0
      : s_q.div + 4'h1;
    case (s_q.susp)
      UVM_S_IDLE:
      begin
        s_d.susp_out = 1'b0;
        s_d.fs_clk = 1'b0;
        if (suspend_req)
        begin
          if (s_q.mode2[uvm_regs_pkg::UVM_M2_DLY_CLK])
          begin
            s_d.susp = UVM_S_CLOCKS;
            s_d.clk_cnt = 3'h0;
            s_d.div = 4'h0;
          end
          else
          begin
            s_d.susp = UVM_S_SUSP;
            s_d.susp_out = 1'b1;
          end
        end
      end
      UVM_S_CLOCKS:
      begin
        if (s_q.div == 4'h0)
          s_d.fs_clk = 1'b1;
        else if (s_q.div == 4'(uvm_regs_pkg::UVM_FS_DIV / 2))
          s_d.fs_clk = 1'b0;
        if (s_q.div == uvm_regs_pkg::UVM_FS_DIV_LAST)
        begin
          s_d.clk_cnt = s_q.clk_cnt + 3'h1;
          if (s_q.clk_cnt == uvm_regs_pkg::UVM_SUSP_CLKS - 3'h1)
          begin
            s_d.susp = UVM_S_SUSP;
            s_d.susp_out = 1'b1;
          end
        end
      end
      UVM_S_SUSP:
      begin
        s_d.fs_clk = 1'b0;
        if (!suspend_req)
        begin
          s_d.susp = UVM_S_IDLE;
          s_d.susp_out = 1'b0;
        end
      end
      default: s_d.susp = UVM_S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.mode1 <= uvm_regs_pkg::UVM_RST_MODE1;
      s_q.mode2 <= uvm_regs_pkg::UVM_RST_MODE2;
      s_q.mode3 <= uvm_regs_pkg::UVM_RST_MODE3;
      s_q.pmdbg <= uvm_regs_pkg::UVM_RST_PMDBG;
      s_q.bar <= uvm_regs_pkg::UVM_RST_BAR;
      s_q.region <= uvm_regs_pkg::UVM_BUF_LARGE;
      s_q.susp <= UVM_S_IDLE;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a register bit or a registered field of the state.
  assign cfg_rdata = s_q.rdata;
  assign op_hit = s_q.hit;
  assign buf_ptr_reset = s_q.ptr_rst;
  assign err_irq = s_q.irq;
  assign wakeup_connected_flag = s_q.wk_conn;
  assign wakeup_enable_flag = s_q.wk_en;
  assign alternate_bus_data_path =
    s_q.mode1[uvm_regs_pkg::UVM_M1_ALT_DMA];
  assign buffer_halted = s_q.halted;
  assign sleep_ws_write_ok = s_q.ws_ok;
  assign buf_region_bytes = s_q.region;
  assign fs_clk_out = s_q.fs_clk;
  assign suspend_enter = s_q.susp_out;
  assign port_drive_en = s_q.mode2[uvm_regs_pkg::UVM_M2_PORT_PWR];
  assign pm_status_masked = s_q.mode2[uvm_regs_pkg::UVM_M2_PM_MASK];
  assign resume_drive = s_q.resume_drv;
  assign restore_start = s_q.restore;
  assign wakeup_signal = s_q.wake;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // One period of the full speed clock, high half first.
  sequence uvm_fs_period;
    fs_clk_out [*4] ##1 !fs_clk_out [*4];
  endsequence

  // The last period, whose low half ends with the entry into suspend.
  sequence uvm_fs_last_period;
    fs_clk_out [*4] ##1 (!fs_clk_out && !suspend_enter) [*3]
      ##1 (!fs_clk_out && suspend_enter);
  endsequence

  AST_MAX_LATENCY_HINT: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_rd && cfg_addr == uvm_regs_pkg::UVM_OFF_MAX_LATENCY_HINT |=> cfg_rdata == 8'h50)
    else $error("max latency value wrong");
  AST_UNDERRUN: assert property (
    @(posedge clk) disable iff (!arst_n)
    data_underrun && s_q.mode1[6] |=> buf_ptr_reset)
    else $error("underrun did not reset pointer");
  AST_TRIPLE: assert property (@(posedge clk) disable iff (!arst_n)
    err_irq && !$past(s_q.mode1[5]) |-> $past(s_q.err_cnt) == 2'h2)
    else $error("error reported before third event");
  AST_WAKE_GATE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !$past(s_q.mode1[4]) |-> !wakeup_connected_flag && !wakeup_enable_flag)
    else $error("wakeup bits not held clear");
  AST_HALT: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == 8'h44 && cfg_wdata[2] |=> buffer_halted)
    else $error("buffer not halted");
  AST_REGION: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == 8'h44
    |=> buf_region_bytes == ($past(cfg_wdata[0]) ? 6'h10 : 6'h20))
    else $error("region size wrong");
  AST_SUSP_CLKS: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.susp == UVM_S_IDLE && suspend_req
    && s_q.mode2[uvm_regs_pkg::UVM_M2_DLY_CLK]
    |=> !fs_clk_out ##1 uvm_fs_period ##1 uvm_fs_period ##1 uvm_fs_period
    ##1 uvm_fs_last_period)
    else $error("suspend clock sequence broken");
  AST_PORT_PWR: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == 8'h45 |=> port_drive_en == $past(cfg_wdata[5]))
    else $error("port drive does not follow power ok");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!arst_n)
    sleep_exit_s4 && s_q.mode2[2] |=> restore_start)
    else $error("restore not started");
  AST_RESTORE_S3: assert property (
    @(posedge clk) disable iff (!arst_n)
    sleep_exit_s3 && s_q.mode3[0] |=> restore_start)
    else $error("restore after light sleep not started");
  AST_WAKEUP: assert property (@(posedge clk) disable iff (!arst_n)
    resume_detect && wakeup_enable_flag |=> wakeup_signal)
    else $error("remote wakeup not signalled");

endmodule

`default_nettype wire

// ### verif/uvm_host_model.sv
// Host bridge model issuing configuration byte cycles and memory probes.
`timescale 1ns/100ps
`default_nettype none

module uvm_host_model (
  // Clock
  input wire logic clk,
  // Configuration cycles
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  // Memory cycles
  output logic [31:0] mem_addr,
  output logic mem_valid,
  input wire logic op_hit
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    mem_addr = 32'h00000000;
    mem_valid = 1'b0;
  end

  // Released lines carry the inverse so stale values never look valid.
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
  endtask

  // Whole doubleword address, no byte lanes.
  task automatic mem_probe(input logic [31:0] a,
                           output logic hit);
    @(negedge clk);
    mem_valid = 1'b1;
    mem_addr = a;
    @(negedge clk);
    mem_valid = 1'b0;
    mem_addr = ~a;
    hit = op_hit;
  endtask
endmodule

`default_nettype wire

// ### verif/usb_host_vendor_mode_regs_bench.sv
// Self-checking testbench for the mode register bank.
`timescale 1ns/100ps
`default_nettype none

module usb_host_vendor_mode_regs_bench;
  logic clk;
  logic arst_n;
  logic [6:0] ev;
  logic no_device, suspend_req, deep_sleep, wcon, wen;
  wire logic cfg_wr, cfg_rd, mem_valid;
  wire logic [7:0] cfg_addr, cfg_wdata;
  wire logic [31:0] mem_addr;
  logic [7:0] cfg_rdata;
  logic op_hit, buf_ptr_reset, err_irq, wakeup_connected_flag;
  logic wakeup_enable_flag, alternate_bus_data_path, buffer_halted;
  logic sleep_ws_write_ok, fs_clk_out, suspend_enter, port_drive_en;
  logic pm_status_masked, resume_drive, restore_start, wakeup_signal;
  logic [5:0] buf_region_bytes;
  logic [7:0] exp_q[$];
  logic rd_pend;
  logic [31:0] seed = 32'h00005a18;
  int np[4];
  int n_mismatch = 0;
  int comparisons = 0;

  uvm_mode_regs uvm_mode_regs_i (.clk, .arst_n, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .mem_addr, .mem_valid, .op_hit,
    .data_underrun(ev[0]), .err_event(ev[1]), .buf_access(ev[2]),
    .no_device, .suspend_req, .resume_detect(ev[3]),
    .sleep_exit_s3(ev[4]), .sleep_exit_s4(ev[5]), .deep_sleep,
    .wake_connected_wr(wcon), .wake_enable_wr(wen), .wake_wr(ev[6]),
    .buf_ptr_reset, .err_irq, .wakeup_connected_flag, .wakeup_enable_flag,
    .alternate_bus_data_path, .buffer_halted, .sleep_ws_write_ok,
    .buf_region_bytes, .fs_clk_out, .suspend_enter, .port_drive_en,
    .pm_status_masked, .resume_drive, .restore_start, .wakeup_signal);

  uvm_host_model uvm_host_model_i (.clk, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .mem_addr, .mem_valid, .op_hit);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    rd_pend <= cfg_rd;
    np[0] += int'(buf_ptr_reset === 1'b1);
    np[1] += int'(err_irq === 1'b1);
    np[2] += int'(restore_start === 1'b1);
    np[3] += int'(wakeup_signal === 1'b1);
  end

  always @(negedge clk)
  begin
    if (rd_pend === 1'b1 && exp_q.size() > 0)
      chk("cfg_rdata", cfg_rdata, exp_q.pop_front());
  end

  // ==========================================================================
  // Stimulus helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    exp_q.push_back(e);
    uvm_host_model_i.cfg_read(a, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    uvm_host_model_i.cfg_write(a, d);
  endtask

  // Read-modify-write keeps every bit outside the mask as it was.
  task automatic rmw(input logic [7:0] a, input logic [7:0] set);
    logic [7:0] d;
    uvm_host_model_i.cfg_read(a, d);
    wr(a, d | set);
  endtask

  task automatic pulse(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev[k] = 1'b0;
    @(negedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    logic [7:0] v;
    logic hit;
    int rises, i;
    logic prev;
    ev = 7'h00;
    {no_device, suspend_req, deep_sleep, wcon, wen} = 5'h00;
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    chk("alt_path", alternate_bus_data_path, 32'h1);
    chk("ws_write", sleep_ws_write_ok, 32'h0);
    chk("region", buf_region_bytes, 32'h20);
    no_device = 1'b1;
    @(negedge clk);
    chk("ws_write", sleep_ws_write_ok, 32'h1);
    chk("port_drive", port_drive_en, 32'h0);
    rd(8'h3f, 8'h50);
    wr(8'h3f, 8'h00);
    rd(8'h3f, 8'h50);
    rd(8'h44, 8'h2a);
    rd(8'h45, 8'h00);
    rd(8'h46, 8'h00);
    rd(8'h48, 8'h00);
    rd(8'h49, 8'h00);
    $display("test reset_values done");
    for (i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      v = seed[7:0];
      wr((i == 0) ? 8'h46 : 8'h47 + 8'(i), v);
      rd((i == 0) ? 8'h46 : 8'h47 + 8'(i), v);
    end
    $display("test storage done");
    wr(8'h44, 8'h00);
    chk("alt_path", alternate_bus_data_path, 32'h0);
    chk("ws_write", sleep_ws_write_ok, 32'h0);
    pulse(0);
    chk("ptr_reset", np[0], 32'h0);
    repeat (3) pulse(1);
    chk("err_irq", np[1], 32'h1);
    repeat (2) pulse(1);
    chk("err_irq", np[1], 32'h1);
    wr(8'h44, 8'h69);
    chk("region", buf_region_bytes, 32'h10);
    chk("alt_path", alternate_bus_data_path, 32'h1);
    pulse(0);
    chk("ptr_reset", np[0], 32'h1);
    pulse(1);
    chk("err_irq", np[1], 32'h2);
    {wcon, wen} = 2'h3;
    pulse(6);
    v = {6'h00, wakeup_connected_flag, wakeup_enable_flag};
    chk("wake_flags", v, 32'h0);
    rmw(8'h44, 8'h10);
    pulse(6);
    v = {6'h00, wakeup_connected_flag, wakeup_enable_flag};
    chk("wake_flags", v, 32'h3);
    pulse(3);
    chk("wakeup", np[3], 32'h1);
    rmw(8'h44, 8'h04);
    chk("halted", buffer_halted, 32'h1);
    pulse(2);
    chk("halted", buffer_halted, 32'h0);
    $display("test mode_one done");
    deep_sleep = 1'b1;
    wr(8'h45, 8'h38);
    v = {5'h00, port_drive_en, pm_status_masked, resume_drive};
    chk("mode_two", v, 32'h7);
    deep_sleep = 1'b0;
    @(negedge clk);
    chk("resume", resume_drive, 32'h0);
    wr(8'h45, 8'h04);
    pulse(5);
    pulse(4);
    chk("restore", np[2], 32'h2);
    wr(8'h45, 8'h00);
    wr(8'h46, 8'h01);
    pulse(5);
    chk("restore", np[2], 32'h2);
    pulse(4);
    chk("restore", np[2], 32'h3);
    $display("test restore done");
    suspend_req = 1'b1;
    @(negedge clk);
    chk("suspend", suspend_enter, 32'h1);
    suspend_req = 1'b0;
    wr(8'h45, 8'h80);
    suspend_req = 1'b1;
    rises = 0;
    prev = fs_clk_out;
    for (i = 0; i < 400 && suspend_enter !== 1'b1; i++)
    begin
      @(negedge clk);
      rises += int'(fs_clk_out === 1'b1 && prev !== 1'b1);
      prev = fs_clk_out;
    end
    if (i == 400)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    chk("fs_clocks", rises, 32'h4);
    @(negedge clk);
    suspend_req = 1'b0;
    $display("test suspend done");
    wr(8'h11, 8'h50);
    wr(8'h12, 8'h34);
    wr(8'h13, 8'h12);
    seed = xs(seed);
    uvm_host_model_i.mem_probe({20'h12345, seed[11:0]}, hit);
    chk("op_hit", hit, 32'h1);
    uvm_host_model_i.mem_probe({20'h12346, seed[11:0]}, hit);
    chk("op_hit", hit, 32'h0);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h50);
    rd(8'h13, 8'h12);
    $display("test decode done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
